// ---- compact_timer_module_bench.sv ----
`timescale 1ns/1ps
module compact_timer_module_bench;
  import ctm_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        sel = 1'b0;
  logic        wr  = 1'b0;
  logic        tbc = 1'b0;
  logic [1:0]  tr  = 2'b00;
  logic [31:0] ad  = 32'h0;
  logic [31:0] wd  = 32'h0;
  logic [31:0] rdat, q, v, n;
  logic [7:0]  ra, rb;
  logic        hro, hrsp, p1, p2, ma, mp, ext, a1, a2;
  logic [7:0]  mdl [9] = '{0: 8'h91, 1: 8'h11, default: 8'h00};
  logic [7:0]  mk [9]  = '{8'hF3, 8'h33, 8'hFF, 8'hFF, 8'h00, 8'h00,
                           8'hFF, 8'h03, 8'h00};
  ctm_cksel_t  ck [4]  = '{CTM_CK_TBC, CTM_CK_EXT_R, CTM_CK_EXT_F, CTM_CK_RSVD};
  int          dv [4]  = '{4, 1, 16, 64};
  int          pr [3]  = '{0, 1, 7};
  int          mismatches = 0;
  int          checks_done = 0;
  int          seed = 32'haa9588c4;
  int          gp = 0, ga = 0, cp = 0, ca = 0, m, e;

  always #5 clk = ~clk;
  // gap in cycles between successive event pulses
  always @(negedge clk) begin
    cp <= (mp === 1'b1) ? 0 : cp + 1;
    ca <= (ma === 1'b1) ? 0 : ca + 1;
    gp <= (mp === 1'b1) ? cp + 1 : gp;
    ga <= (ma === 1'b1) ? ca + 1 : ga;
  end

  ctm_top dut_u (.CORE_CLK_I(clk), .RST_I(rst), .HSEL_I(sel), .HADDR_I(ad),
    .HTRANS_I(tr), .HWRITE_I(wr), .HSIZE_I(3'b010), .HWDATA_I(wd),
    .HREADY_I(hro), .HRDATA_O(rdat), .HREADYOUT_O(hro), .HRESP_O(hrsp),
    .TBC_TICK_I(tbc), .EXT_CLK_I(ext), .ALT_PIN1_I(a1), .ALT_PIN2_I(a2),
    .PIN1_O(p1), .PIN2_O(p2), .ROUTE_A_O(ra), .ROUTE_B_O(rb),
    .MATCH_A_O(ma), .MATCH_P_O(mp));
  ctm_far far_u (.clk_i(clk), .ext_o(ext), .alt1_o(a1), .alt2_o(a2));

  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    checks_done++;
    if (s !== x) begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, x);
    end
  endtask : chk
  task automatic wrap_up();
    if (mismatches == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : wrap_up
  // hold until hready is seen high at a falling edge, then wait for the next rising edge
  task automatic wt();
    do @(negedge clk); while (hro !== 1'b1);
    q = rdat;
    @(posedge clk);
  endtask : wt
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sel <= 1'b1;
    ad <= {24'h0, a};
    tr <= 2'b10;
    wr <= w;
    wt();
    sel <= 1'b0;
    tr <= 2'b00;
    wd <= {24'h0, d};
    wt();
  endtask : bus
  task automatic run(input logic [7:0] d);
    bus(1'b1, 8'h08, 8'h00);
    bus(1'b1, 8'h08, d);
  endtask : run
  task automatic tk(input int k);
    repeat (k) begin
      @(posedge clk);
      tbc <= 1'b1;
      @(posedge clk);
      tbc <= 1'b0;
    end
  endtask : tk
  // count cycles with the first pin high over a window
  task automatic duty(input int w, input int h);
    m = 0;
    repeat (w) begin
      @(negedge clk);
      m += p1;
    end
    chk(m, h);
  endtask : duty
  // high byte first, low byte from the holding buffer
  task automatic rdc();
    bus(1'b0, 8'h14, 8'h00);
    v = {22'h0, q[1:0], 8'h00};
    bus(1'b0, 8'h10, 8'h00);
    v[7:0] = q[7:0];
  endtask : rdc

  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    // reset values, masked writes, read-only and unmapped places
    for (int i = 0; i < 9; i++) begin
      bus(1'b0, 8'(4 * i), 8'h00);
      chk(q, {24'h0, mdl[i]});
      bus(1'b1, 8'(4 * i), 8'hFF);
      mdl[i] = mk[i];
      bus(1'b0, 8'(4 * i), 8'h00);
      chk(q, {24'h0, mdl[i]});
    end
    chk({ra, rb, hrsp}, {mdl[0], mdl[1], 1'b0});
    bus(1'b1, 8'h0C, 8'h00);
    // compare pair through the shared buffer
    n = $random(seed);
    bus(1'b1, 8'h18, n[7:0]);
    bus(1'b1, 8'h1C, n[15:8]);
    bus(1'b0, 8'h1C, 8'h00);
    chk(q, {30'h0, n[9:8]});
    bus(1'b0, 8'h18, 8'h00);
    chk(q, {24'h0, n[7:0]});
    bus(1'b1, 8'h18, ~n[7:0]);
    bus(1'b0, 8'h1C, 8'h00);
    bus(1'b0, 8'h18, 8'h00);
    chk(q, {24'h0, n[7:0]});
    bus(1'b0, 8'h10, 8'h00);
    chk(q, {24'h0, n[7:0]});
    // event sources, reserved code, run rise and stop
    foreach (ck[i]) begin
      m = 3 + ($random(seed) & 7);
      e = (ck[i] == CTM_CK_RSVD) ? 0 : m;
      run({1'b0, ck[i], 4'b1000});
      fork
        far_u.edges(m);
        tk(m);
      join
      repeat (6) @(posedge clk);
      bus(1'b1, 8'h08, {1'b0, ck[i], 4'b0000});
      rdc();
      chk(v, e);
      tk(2);
      rdc();
      chk(v, e);
    end
    // pause holds, release resumes from held value
    run(8'h48);
    tk(3);
    bus(1'b1, 8'h08, 8'hC8);
    tk(4);
    bus(1'b1, 8'h08, 8'h48);
    tk(2);
    bus(1'b1, 8'h08, 8'h40);
    rdc();
    chk(v, 5);
    // system clock ratios
    for (int k = 0; k < 4; k++) begin
      run({1'b0, 3'(k), 4'b1000});
      repeat (256) @(posedge clk);
      bus(1'b1, 8'h08, 8'h00);
      rdc();
      chk({31'h0, v >= 256 / dv[k] && v <= 264 / dv[k] + 1}, 1);
    end
    // period match spacing, zero means full overflow
    foreach (pr[i]) begin
      e = (pr[i] != 0) ? pr[i] * 128 : 1024;
      run({5'b00011, 3'(pr[i])});
      repeat (2 * e + 20) @(posedge clk);
      chk(gp, e);
    end
    // compare a match clears the counter
    bus(1'b1, 8'h0C, 8'h01);
    n = $random(seed);
    e = 32 + n[7:0];
    bus(1'b1, 8'h18, 8'(e));
    bus(1'b1, 8'h1C, 8'(e >> 8));
    run(8'h18);
    repeat (2 * e + 20) @(posedge clk);
    chk(ga, e);
    // compare output clears, sets and toggles the routed pin
    for (int k = 1; k < 4; k++) begin
      bus(1'b1, 8'h0C, {2'b00, 2'(k), 4'b0001});
      repeat (e + 4) @(posedge clk);
      duty(2 * e, (k == 1) ? 0 : (k == 2) ? 2 * e : e);
    end
    // pins keep their other use when not routed
    bus(1'b1, 8'h00, 8'h00);
    repeat (4) begin
      n = $random(seed);
      far_u.alt(n[1:0]);
      repeat (3) @(negedge clk);
      chk({p2, p1}, n[1:0]);
    end
    // second pin carries the inverse in pwm output
    bus(1'b1, 8'h00, 8'h03);
    bus(1'b1, 8'h0C, 8'h82);
    run(8'h18);
    repeat (6) begin
      repeat (37) @(negedge clk);
      chk({31'h0, p1 ^ p2}, 1);
    end
    duty(1024, e);
    wrap_up();
  end

  initial begin
    repeat (40000) @(posedge clk);
    mismatches++;
    wrap_up();
  end
endmodule : compact_timer_module_bench

// ---- ctm_far.sv ----
`timescale 1ns/1ps
module ctm_far (
  // clock
  input  wire logic clk_i,
  // pins
  output logic      ext_o,
  output logic      alt1_o,
  output logic      alt2_o
);
  // pin rests low between bursts, edges spaced well apart
  initial begin
    ext_o = 1'b0;
    alt1_o = 1'b0;
    alt2_o = 1'b0;
  end
  task automatic edges(input int n);
    repeat (n) begin
      repeat (3) @(posedge clk_i);
      ext_o <= 1'b1;
      repeat (3) @(posedge clk_i);
      ext_o <= 1'b0;
    end
  endtask : edges
  task automatic alt(input logic [1:0] v);
    @(posedge clk_i);
    {alt2_o, alt1_o} <= v;
  endtask : alt
endmodule : ctm_far

// ---- ctm_map.svh ----
`ifndef CTM_MAP_SVH
`define CTM_MAP_SVH
// register byte offsets, low address byte
`define CTM_OFS_ROUTE_A    8'h00
`define CTM_OFS_ROUTE_B    8'h04
`define CTM_OFS_CTL_A      8'h08
`define CTM_OFS_CTL_B      8'h0C
`define CTM_OFS_COUNT_LO   8'h10
`define CTM_OFS_COUNT_HI   8'h14
`define CTM_OFS_MATCH_LO   8'h18
`define CTM_OFS_MATCH_HI   8'h1C
// reset values and implemented-bit masks
`define CTM_ROUTE_A_RST    8'h91
`define CTM_ROUTE_A_MASK   8'hF3
`define CTM_ROUTE_B_RST    8'h11
`define CTM_ROUTE_B_MASK   8'h33
`define CTM_CTL_RST        8'h00
`define CTM_HI_MASK        8'h03
// control a fields
`define CTM_PAUSE_BIT      7
`define CTM_CKSEL_HI       6
`define CTM_CKSEL_LO       4
`define CTM_RUN_BIT        3
`define CTM_PERIOD_HI      2
// control b fields
`define CTM_MODE_HI        7
`define CTM_MODE_LO        6
`define CTM_IO_HI          5
`define CTM_IO_LO          4
`define CTM_INIT_BIT       3
`define CTM_POL_BIT        2
`define CTM_INV2_BIT       1
`define CTM_CLRSEL_BIT     0
// prescaler terminal counts
`define CTM_PRE_DIV4       6'h03
`define CTM_PRE_DIV16      6'h0F
`define CTM_PRE_DIV64      6'h3F
`endif

// ---- ctm_pkg.sv ----
package ctm_pkg;
  typedef enum logic [2:0] {
    CTM_CK_SYS4   = 3'b000,
    CTM_CK_SYS    = 3'b001,
    CTM_CK_HI16   = 3'b010,
    CTM_CK_HI64   = 3'b011,
    CTM_CK_TBC    = 3'b100,
    CTM_CK_RSVD   = 3'b101,
    CTM_CK_EXT_R  = 3'b110,
    CTM_CK_EXT_F  = 3'b111
  } ctm_cksel_t;
  typedef enum logic [1:0] {
    CTM_MODE_CMP  = 2'b00,
    CTM_MODE_TMR  = 2'b01,
    CTM_MODE_PWM  = 2'b10,
    CTM_MODE_EVT  = 2'b11
  } ctm_mode_t;
  typedef enum logic [1:0] {
    CTM_BUS_IDLE  = 2'b00,
    CTM_BUS_WR    = 2'b01,
    CTM_BUS_RDW   = 2'b10,
    CTM_BUS_RDL   = 2'b11
  } ctm_bus_t;
endpackage : ctm_pkg

// ---- ctm_top.sv ----
// The AHB-Lite interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "ctm_map.svh"
// Summary of operation
// RL1 - 10-bit up-counter advances per selected clock edge when on and unpaused
// RL2 - period compares top three count bits; compare A compares all ten
// RL3 - software can only clear the counter, by raising the run bit
// RL4 - overflow or selected match clears the counter and raises an event
// RL5 - pause bit holds the count; clearing it resumes from held value
// RL6 - clock select: sys/4, sys, high/16, high/64, time base, pin edges
// RL7 - reserved clock select code connects no clock; counter stays
// RL8 - count readable as byte pair; compare A read/write byte pair
// RL9 - high bytes direct; low bytes via one shared holding buffer
// RL10 - low write fills buffer; high write loads high and buffer to low
// RL11 - high read returns high and latches low byte into buffer
// RL12 - software writes low then high, reads high then low
// RL13 - pin enable bit one gives pin to timer, zero keeps other use
// RL14 - unimplemented bits read zero and ignore writes
// RL15 - modes: compare match output, timer/event count, PWM output
// RL16 - two output pins; second carries same or inverted signal
// RL17 - run rise clears counter; run fall stops and keeps value
// RL18 - period match every 128 clocks times field; zero means 1024
// RL19 - separate event outputs for compare A and period match
// RL20 - external clock pin synchronised; one count per chosen edge
module ctm_top (
  // clock and reset
  input  wire logic               CORE_CLK_I,
  input  wire logic               RST_I,
  // ahb-lite slave
  input  wire logic               HSEL_I,
  input  wire logic [31:0]        HADDR_I,
  input  wire logic [1:0]         HTRANS_I,
  input  wire logic               HWRITE_I,
  input  wire logic [2:0]         HSIZE_I,
  input  wire logic [31:0]        HWDATA_I,
  input  wire logic               HREADY_I,
  output logic      [31:0]        HRDATA_O,
  output logic                    HREADYOUT_O,
  output logic                    HRESP_O,
  // clock sources
  input  wire logic               TBC_TICK_I,
  input  wire logic               EXT_CLK_I,
  // shared pins
  input  wire logic               ALT_PIN1_I,
  input  wire logic               ALT_PIN2_I,
  output logic                    PIN1_O,
  output logic                    PIN2_O,
  output logic      [7:0]         ROUTE_A_O,
  output logic      [7:0]         ROUTE_B_O,
  // events
  output logic                    MATCH_A_O,
  output logic                    MATCH_P_O
);
  import ctm_pkg::*;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a == o);
  endfunction : hit

  logic [7:0]  route_a;
  logic [7:0]  route_b;
  logic [7:0]  ctl_a;
  logic [7:0]  ctl_b;
  logic [9:0]  cmp_a;
  logic [7:0]  hold_buf;
  logic [9:0]  count;
  logic [5:0]  pre;
  logic        ext_s1;
  logic        ext_s2;
  logic        ext_s3;
  logic        run_q;
  logic        out_lvl;
  logic [7:0]  addr_q;
  ctm_bus_t    bus_st;
  ctm_bus_t    next_bus_st;

  // bus decode
  wire        addr_ok = HSEL_I & HTRANS_I[1] & HREADY_I;
  wire        wr_en   = (bus_st == CTM_BUS_WR);
  wire        rd_en   = (bus_st == CTM_BUS_RDW);
  wire [7:0]  wd      = HWDATA_I[7:0];
  wire        s_ra    = hit(addr_q, `CTM_OFS_ROUTE_A);
  wire        s_rb    = hit(addr_q, `CTM_OFS_ROUTE_B);
  wire        s_ca    = hit(addr_q, `CTM_OFS_CTL_A);
  wire        s_cb    = hit(addr_q, `CTM_OFS_CTL_B);
  wire        s_dl    = hit(addr_q, `CTM_OFS_COUNT_LO);
  wire        s_dh    = hit(addr_q, `CTM_OFS_COUNT_HI);
  wire        s_al    = hit(addr_q, `CTM_OFS_MATCH_LO);
  wire        s_ah    = hit(addr_q, `CTM_OFS_MATCH_HI);
  wire [7:0]  rd_mux  =
    s_ra ? route_a :
    s_rb ? route_b :
    s_ca ? ctl_a :
    s_cb ? ctl_b :
    (s_dl | s_al) ? hold_buf :                           // [RL9]
    s_dh ? {6'h00, count[9:8]} :                         // [RL8] [RL14]
    s_ah ? {6'h00, cmp_a[9:8]} : 8'h00;                  // [RL8] [RL14]

  always_comb begin
    case (bus_st)
      CTM_BUS_RDW: next_bus_st = CTM_BUS_RDL;
      default: begin
        if (addr_ok) begin
          next_bus_st = HWRITE_I ? CTM_BUS_WR : CTM_BUS_RDW;
        end else begin
          next_bus_st = CTM_BUS_IDLE;
        end
      end
    endcase
  end

  assign HREADYOUT_O = (bus_st != CTM_BUS_RDW);
  assign HRESP_O     = 1'b0;
  assign ROUTE_A_O   = route_a;
  assign ROUTE_B_O   = route_b;

  // clock selection and counting
  ctm_cksel_t cksel;
  ctm_mode_t  mode;
  assign cksel = ctm_cksel_t'(ctl_a[`CTM_CKSEL_HI:`CTM_CKSEL_LO]);
  assign mode  = ctm_mode_t'(ctl_b[`CTM_MODE_HI:`CTM_MODE_LO]);
  wire        ext_rise = ext_s2 & ~ext_s3;                   // [RL20]
  wire        ext_fall = ~ext_s2 & ext_s3;                   // [RL20]
  wire        tick =
    (cksel == CTM_CK_SYS4)  ? (pre[1:0] == 2'(`CTM_PRE_DIV4)) :  // [RL6]
    (cksel == CTM_CK_SYS)   ? 1'b1 :
    (cksel == CTM_CK_HI16)  ? (pre[3:0] == 4'(`CTM_PRE_DIV16)) :
    (cksel == CTM_CK_HI64)  ? (pre == `CTM_PRE_DIV64) :
    (cksel == CTM_CK_TBC)   ? TBC_TICK_I :
    (cksel == CTM_CK_EXT_R) ? ext_rise :
    (cksel == CTM_CK_EXT_F) ? ext_fall : 1'b0;               // [RL7]
  wire        run      = ctl_a[`CTM_RUN_BIT];
  wire        pause    = ctl_a[`CTM_PAUSE_BIT];
  wire        run_rise = run & ~run_q;                       // [RL17]
  wire        advance  = run & ~pause & tick;                // [RL1] [RL5]
  wire [9:0]  count_inc = count + 10'h001;
  wire        hit_p = (count_inc[9:7] == ctl_a[`CTM_PERIOD_HI:0]) &
                      (count_inc[6:0] == 7'h00);             // [RL2] [RL18]
  wire        hit_a = (count_inc == cmp_a);                  // [RL2]
  wire        clr_sel = ctl_b[`CTM_CLRSEL_BIT];
  wire        clr_hit = clr_sel ? hit_a : hit_p;
  wire [9:0]  next_count =
    run_rise ? 10'h000 :                                     // [RL3]
    (advance & clr_hit) ? 10'h000 :                          // [RL4]
    advance ? count_inc : count;
  wire [7:0]  next_hold =
    (wr_en & s_al) ? wd :                                    // [RL10]
    (rd_en & s_dh) ? count[7:0] :                            // [RL11]
    (rd_en & s_ah) ? cmp_a[7:0] : hold_buf;                  // [RL11]
  wire        cmp_evt  = advance & hit_a & (mode == CTM_MODE_CMP);
  wire [1:0]  io_act   = ctl_b[`CTM_IO_HI:`CTM_IO_LO];
  wire        next_out =
    run_rise ? ctl_b[`CTM_INIT_BIT] :                        // [RL15]
    (mode == CTM_MODE_PWM) ? (count < cmp_a) :               // [RL15]
    !cmp_evt ? out_lvl :
    (io_act == 2'b01) ? 1'b0 :
    (io_act == 2'b10) ? 1'b1 :
    (io_act == 2'b11) ? ~out_lvl : out_lvl;
  wire        pin1_lvl = out_lvl ^ ctl_b[`CTM_POL_BIT];
  wire        pin2_lvl = pin1_lvl ^ ctl_b[`CTM_INV2_BIT];    // [RL16]

  // bus and register state
  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      bus_st   <= CTM_BUS_IDLE;
      addr_q   <= 8'h00;
      HRDATA_O <= 32'h0000_0000;
    end else begin
      bus_st <= next_bus_st;
      if (addr_ok) begin
        addr_q <= HADDR_I[7:0];
      end
      if (rd_en) begin
        HRDATA_O <= {24'h00_0000, rd_mux};
      end
    end
  end

  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      route_a <= `CTM_ROUTE_A_RST;
      route_b <= `CTM_ROUTE_B_RST;
      ctl_a   <= `CTM_CTL_RST;
      ctl_b   <= `CTM_CTL_RST;
      cmp_a   <= 10'h000;
    end else if (wr_en) begin
      if (s_ra) route_a <= wd & `CTM_ROUTE_A_MASK;           // [RL14]
      if (s_rb) route_b <= wd & `CTM_ROUTE_B_MASK;           // [RL14]
      if (s_ca) ctl_a <= wd;
      if (s_cb) ctl_b <= wd;
      if (s_ah) cmp_a <= {wd[1:0], hold_buf};                // [RL10]
    end
  end

  // counter, prescaler and pin sync
  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      count    <= 10'h000;
      hold_buf <= 8'h00;
      pre      <= 6'h00;
      ext_s1   <= 1'b0;
      ext_s2   <= 1'b0;
      ext_s3   <= 1'b0;
      run_q    <= 1'b0;
    end else begin
      count    <= next_count;
      hold_buf <= next_hold;
      pre      <= pre + 6'h01;
      ext_s1   <= EXT_CLK_I;
      ext_s2   <= ext_s1;
      ext_s3   <= ext_s2;
      run_q    <= run;
    end
  end

  // outputs and events
  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      out_lvl   <= 1'b0;
      PIN1_O    <= 1'b0;
      PIN2_O    <= 1'b0;
      MATCH_A_O <= 1'b0;
      MATCH_P_O <= 1'b0;
    end else begin
      out_lvl   <= next_out;
      PIN1_O    <= route_a[0] ? pin1_lvl : ALT_PIN1_I;       // [RL13]
      PIN2_O    <= route_a[1] ? pin2_lvl : ALT_PIN2_I;       // [RL13]
      MATCH_A_O <= advance & hit_a & ~run_rise;              // [RL19]
      MATCH_P_O <= advance & hit_p & ~run_rise;              // [RL19]
    end
  end

  // checks
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (RST_I);

  count_step_a: assert property (  // [RL1]
    (advance && !run_rise && !clr_hit) |=> count == $past(count_inc))
    else $error("counter did not step by one");
  pause_hold_a: assert property (  // [RL5]
    (run && pause && !run_rise) |=> count == $past(count))
    else $error("paused counter moved");
  reserved_hold_a: assert property (  // [RL7]
    (cksel == CTM_CK_RSVD && !run_rise) |=> $stable(count))
    else $error("counter moved with no clock");
  run_clear_a: assert property (  // [RL17]
    $rose(run) |=> count == 10'h000)
    else $error("run rise did not clear counter");
  period_clear_a: assert property (  // [RL4]
    (advance && hit_p && !clr_sel && !run_rise)
      |=> count == 10'h000 && MATCH_P_O)
    else $error("period match did not clear");
  match_a_src_a: assert property (  // [RL19]
    MATCH_A_O |-> $past(advance) && $past(count_inc) == $past(cmp_a))
    else $error("compare a event without match");
  hold_wr_a: assert property (  // [RL10]
    (wr_en && s_ah)
      |=> cmp_a == {$past(HWDATA_I[1:0]), $past(hold_buf)})
    else $error("compare high write lost buffer");
  hold_rd_a: assert property (  // [RL11]
    (rd_en && s_dh) |=> hold_buf == $past(count[7:0]))
    else $error("count high read did not latch low");
  zero_bits_a: assert property (  // [RL14]
    (bus_st == CTM_BUS_RDL && (s_dh || s_ah))
      |-> HRDATA_O[31:2] == 30'h0000_0000)
    else $error("unimplemented bits not zero");
  ext_once_a: assert property (  // [RL20]
    (advance && cksel == CTM_CK_EXT_R) |=> !advance)
    else $error("two counts for one pin edge");
  pin_route_a: assert property (  // [RL13]
    route_a[0] |=> PIN1_O == $past(pin1_lvl))
    else $error("routed pin not driven by timer");
  pin_inv_a: assert property (  // [RL16]
    (route_a[1:0] == 2'b11 && ctl_b[`CTM_INV2_BIT]) |=> PIN2_O != PIN1_O)
    else $error("second pin not inverted");
  // register, clock source and output level checks
  stop_keep_a: assert property (  // [RL17]
    !run |=> count == $past(count))
    else $error("stopped counter moved");
  compare_clear_a: assert property (  // [RL4]
    (advance && hit_a && clr_sel && !run_rise)
      |=> count == 10'h000 && MATCH_A_O)
    else $error("compare match did not clear");
  full_wrap_a: assert property (  // [RL18]
    (advance && count == 10'h3FF && !clr_sel && !run_rise &&
     ctl_a[`CTM_PERIOD_HI:0] == 3'h0) |=> count == 10'h000 && MATCH_P_O)
    else $error("zero period did not wrap at full count");
  match_p_src_a: assert property (  // [RL19]
    MATCH_P_O |-> $past(advance) && $past(hit_p))
    else $error("period event without match");
  sys_tick_a: assert property (  // [RL6]
    (run && !pause && cksel == CTM_CK_SYS && !run_rise && !clr_hit)
      |=> count == $past(count_inc))
    else $error("system clock did not count every cycle");
  tbc_idle_a: assert property (  // [RL6]
    (cksel == CTM_CK_TBC && !TBC_TICK_I && !run_rise) |=> $stable(count))
    else $error("time base counted without a tick");
  div4_gap_a: assert property (  // [RL6]
    (advance && cksel == CTM_CK_SYS4)
      |=> !(advance && cksel == CTM_CK_SYS4))
    else $error("quarter rate counted twice in a row");
  fall_once_a: assert property (  // [RL20]
    (advance && cksel == CTM_CK_EXT_F) |=> !advance)
    else $error("two counts for one falling edge");
  ro_count_a: assert property (  // [RL3]
    (wr_en && (s_dl || s_dh) && !advance && !run_rise) |=> $stable(count))
    else $error("count register took a write");
  low_read_a: assert property (  // [RL9]
    (rd_en && (s_dl || s_al))
      |=> HRDATA_O == {24'h00_0000, $past(hold_buf)})
    else $error("low byte read not from buffer");
  high_read_a: assert property (  // [RL11]
    (rd_en && s_ah)
      |=> hold_buf == $past(cmp_a[7:0]) &&
          HRDATA_O[1:0] == $past(cmp_a[9:8]))
    else $error("compare high read did not latch low");
  low_write_a: assert property (  // [RL10]
    (wr_en && s_al)
      |=> hold_buf == $past(HWDATA_I[7:0]) && $stable(cmp_a))
    else $error("compare low write reached the register");
  route_bits_a: assert property (  // [RL14]
    (ROUTE_A_O & ~`CTM_ROUTE_A_MASK) == 8'h00 &&
    (ROUTE_B_O & ~`CTM_ROUTE_B_MASK) == 8'h00)
    else $error("unimplemented route bit set");
  init_level_a: assert property (  // [RL15]
    run_rise |=> out_lvl == $past(ctl_b[`CTM_INIT_BIT]))
    else $error("run rise did not load initial level");
  pwm_level_a: assert property (  // [RL15]
    (mode == CTM_MODE_PWM && !run_rise) |=> out_lvl == $past(count < cmp_a))
    else $error("pwm level wrong");
  toggle_a: assert property (  // [RL15]
    (cmp_evt && io_act == 2'b11 && !run_rise) |=> out_lvl != $past(out_lvl))
    else $error("compare match did not toggle output");
  clear_low_a: assert property (  // [RL15]
    (cmp_evt && io_act == 2'b01 && !run_rise) |=> !out_lvl)
    else $error("compare match did not drive output low");
  set_high_a: assert property (  // [RL15]
    (cmp_evt && io_act == 2'b10 && !run_rise) |=> out_lvl)
    else $error("compare match did not drive output high");
  pin_same_a: assert property (  // [RL16]
    (route_a[1] && !ctl_b[`CTM_INV2_BIT]) |=> PIN2_O == $past(pin1_lvl))
    else $error("second pin differs from first");
  pin_alt_a: assert property (  // [RL13]
    !route_a[0] |=> PIN1_O == $past(ALT_PIN1_I))
    else $error("unrouted pin lost its other use");

  pause_c: cover property (run && pause ##1 run && !pause);
  ext_c: cover property (advance && cksel == CTM_CK_EXT_F);
  pwm_c: cover property (mode == CTM_MODE_PWM && MATCH_P_O);
  pair_c: cover property (rd_en && s_dh ##2 rd_en && s_dl);
  tog_c: cover property (cmp_evt && io_act == 2'b11);
endmodule : ctm_top
